// ==== idr_top.v ====
// Purpose: Disabling stage of two push-button input channels
// Assumes: Inputs synchronous to SYS_CLK; Wishbone classic register bus
// Notes:   One telegram per channel per cycle at most
//
// The Wishbone slave port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "idr_regs.vh"

// What this block does
// - Each channel has an enable bit for its disabling function, and with it off the disabling object does nothing.
// - A polarity bit selects whether a one or a zero on the disabling object disables the channel, one by default.
// - When disabling starts, a selectable reaction runs: none by default, rising value, falling value or present state.
// - When disabling ends, a second selectable reaction with the same four choices runs.
// - A reaction of none sends nothing at that transition.
// - The rising reaction sends the value set for a rising input edge.
// - The falling reaction sends the value set for a falling input edge.
// - The rising reaction acts only when the channel sends on rising edges or on both edges.
// - The falling reaction acts only when the channel sends on falling edges or on both edges.
// - The present-state reaction sends the rising value for a high input and the falling value for a low one.
// - The present-state reaction acts only when the channel sends on both edges.
// - The second channel behaves and is configured exactly like the first.
module idr_top
(
	// Clock and reset
	input  wire        SYS_CLK,
	input  wire        RST_N,
	// Wishbone slave
	input  wire        WB_CYC_I,
	input  wire        WB_STB_I,
	input  wire        WB_WE_I,
	input  wire [7:0]  WB_ADR_I,
	input  wire [3:0]  WB_SEL_I,
	input  wire [31:0] WB_DAT_I,
	output reg  [31:0] WB_DAT_O,
	output reg         WB_ACK_O,
	// Contacts and disabling objects
	input  wire [1:0]  BTN_IN,
	input  wire [1:0]  DIS_OBJ,
	// Telegram sender
	output wire [1:0]  TX_STB,
	output wire [7:0]  TX_VAL0,
	output wire [7:0]  TX_VAL1,
	output wire [1:0]  DISABLED
);

	reg  [15:0] ctrl_q;
	reg  [31:0] val_q;
	wire [1:0]  dis_now;
	wire [1:0]  lvl_now;
	wire        req;
	wire        wr_take;
	wire        rd_take;
	reg  [31:0] rd_d;
	wire [15:0] tx_val_w;

	// Channel states, one-hot
	localparam [1:0] ST_OPEN = 2'b01;
	localparam [1:0] ST_SHUT = 2'b10;

	// Whether a transition reaction may send under the send mode
	function react_ok;
		input [1:0] r;
		input [1:0] mode;
		begin
			case (r)
				`IDR_REACT_RISE:
					react_ok = mode[0];
				`IDR_REACT_FALL:
					react_ok = mode[1];
				`IDR_REACT_STATE:
					react_ok = (mode == `IDR_MODE_BOTH);
				default:
					react_ok = 1'b0;
			endcase
		end
	endfunction

	// Whether a reaction sends the rising value
	function react_rise;
		input [1:0] r;
		input       lvl;
		begin
			case (r)
				`IDR_REACT_RISE:
					react_rise = 1'b1;
				`IDR_REACT_FALL:
					react_rise = 1'b0;
				`IDR_REACT_STATE:
					react_rise = lvl;
				default:
					react_rise = 1'b0;
			endcase
		end
	endfunction

	// Returns {send, pick_rising} for a disable transition
	function [1:0] react;
		input [1:0] r;
		input [1:0] mode;
		input       lvl;
		begin
			react = {react_ok(r, mode), react_rise(r, lvl)};
		end
	endfunction

	// Bus slave: ack one cycle after the request, then dropped
	assign req     = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
	assign wr_take = req & WB_WE_I;
	assign rd_take = req & ~WB_WE_I;

	// Read mux; unused bits read as zero
	always @*
	begin
		rd_d = 32'h00000000;
		case (WB_ADR_I)
			`IDR_OFS_CTRL0:
			begin
				rd_d[7:0] = ctrl_q[7:0];
			end
			`IDR_OFS_VAL0:
			begin
				rd_d[15:0] = val_q[15:0];
			end
			`IDR_OFS_CTRL1:
			begin
				rd_d[7:0] = ctrl_q[15:8];
			end
			`IDR_OFS_VAL1:
			begin
				rd_d[15:0] = val_q[31:16];
			end
			`IDR_OFS_STATUS:
			begin
				rd_d[3:0] = {lvl_now, dis_now};
			end
			default:
			begin
				rd_d = 32'h00000000;
			end
		endcase
	end

	always @(posedge SYS_CLK)
	begin
		if (!RST_N)
		begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h00000000;
			ctrl_q   <= {`IDR_CTRL_RST, `IDR_CTRL_RST};
			val_q    <= {`IDR_VAL_RST, `IDR_VAL_RST};
		end
		else
		begin
			WB_ACK_O <= req;
			WB_DAT_O <= rd_take ? rd_d : 32'h00000000;
			if (wr_take)
			begin
				// Same layout for both channels
				case (WB_ADR_I)
					`IDR_OFS_CTRL0:
					begin
						if (WB_SEL_I[0])
							ctrl_q[7:0] <= WB_DAT_I[7:0];
					end
					`IDR_OFS_CTRL1:
					begin
						if (WB_SEL_I[0])
							ctrl_q[15:8] <= WB_DAT_I[7:0];
					end
					`IDR_OFS_VAL0:
					begin
						if (WB_SEL_I[0])
							val_q[7:0] <= WB_DAT_I[7:0];
						if (WB_SEL_I[1])
							val_q[15:8] <= WB_DAT_I[15:8];
					end
					`IDR_OFS_VAL1:
					begin
						if (WB_SEL_I[0])
							val_q[23:16] <= WB_DAT_I[7:0];
						if (WB_SEL_I[1])
							val_q[31:24] <= WB_DAT_I[15:8];
					end
					default:
					begin
						// Status and unmapped offsets ignore writes
						ctrl_q <= ctrl_q;
					end
				endcase
			end
		end
	end

	genvar c;
	generate
		for (c = 0; c < 2; c = c + 1)
		begin : g_ch
			wire [7:0] cfg;
			wire [1:0] mode;
			wire [7:0] v_rise;
			wire [7:0] v_fall;
			wire       dis_d;
			wire       rise_e;
			wire       fall_e;
			wire [1:0] r_start;
			wire [1:0] r_end;
			wire       en_bit;
			wire       pol_bit;
			wire       dis_q;
			reg  [1:0] st_q;
			reg  [1:0] st_d;
			reg        stb_d;
			reg  [7:0] val_d;
			reg        lvl_q;
			reg        stb_q;
			reg  [7:0] val_o_q;

			assign cfg    = ctrl_q[8*c +: 8];
			assign mode   = cfg[`IDR_CTRL_MODE_LO +: 2];
			assign v_rise = val_q[16*c +: 8];
			assign v_fall = val_q[16*c+8 +: 8];
			// Enable gates the object; polarity bit flips its sense
			assign en_bit  = cfg[`IDR_CTRL_EN];
			assign pol_bit = cfg[`IDR_CTRL_POL];
			assign dis_d   = en_bit & (DIS_OBJ[c] ^ pol_bit);
			assign dis_q   = st_q[1];
			assign rise_e = BTN_IN[c] & ~lvl_q;
			assign fall_e = ~BTN_IN[c] & lvl_q;
			assign r_start = react(cfg[`IDR_CTRL_START_LO +: 2], mode,
				BTN_IN[c]);
			assign r_end   = react(cfg[`IDR_CTRL_END_LO +: 2], mode,
				BTN_IN[c]);

			// Value only moves with a strobe, so the sender sees a stable word
			always @*
			begin
				st_d  = st_q;
				stb_d = 1'b0;
				val_d = val_o_q;
				case (st_q)
					ST_OPEN:
					begin
						// Transition reaction wins over a coincident edge
						if (dis_d)
						begin
							st_d  = ST_SHUT;
							stb_d = r_start[1];
							if (r_start[1])
								val_d = r_start[0] ? v_rise : v_fall;
						end
						else if (rise_e & mode[0])
						begin
							stb_d = 1'b1;
							val_d = v_rise;
						end
						else if (fall_e & mode[1])
						begin
							stb_d = 1'b1;
							val_d = v_fall;
						end
					end
					ST_SHUT:
					begin
						// Edges are dropped while shut
						if (!dis_d)
						begin
							st_d  = ST_OPEN;
							stb_d = r_end[1];
							if (r_end[1])
								val_d = r_end[0] ? v_rise : v_fall;
						end
					end
					default:
					begin
						st_d = ST_OPEN;
					end
				endcase
			end

			always @(posedge SYS_CLK)
			begin
				if (!RST_N)
				begin
					st_q    <= ST_OPEN;
					lvl_q   <= 1'b0;
					stb_q   <= 1'b0;
					val_o_q <= 8'h00;
				end
				else
				begin
					st_q    <= st_d;
					lvl_q   <= BTN_IN[c];
					stb_q   <= stb_d;
					val_o_q <= val_d;
				end
			end

			assign TX_STB[c]   = stb_q;
			assign DISABLED[c] = dis_q;
			assign dis_now[c]  = dis_q;
			assign lvl_now[c]  = lvl_q;
			assign tx_val_w[8*c +: 8] = val_o_q;
		end
	endgenerate

	assign TX_VAL0 = tx_val_w[7:0];
	assign TX_VAL1 = tx_val_w[15:8];

endmodule // idr_top
`default_nettype wire

// ==== idr_regs.vh ====
// Purpose: Register map and field layout of the input disable stage
// Assumes: Wishbone classic slave, 32-bit data, byte addresses
// Notes:   Definitions only
`ifndef IDR_REGS_VH
`define IDR_REGS_VH

`define IDR_ADDR_W       8
`define IDR_OFS_CTRL0    8'h00
`define IDR_OFS_VAL0     8'h04
`define IDR_OFS_CTRL1    8'h08
`define IDR_OFS_VAL1     8'h0C
`define IDR_OFS_STATUS   8'h10

`define IDR_CTRL_EN      0
`define IDR_CTRL_POL     1
`define IDR_CTRL_MODE_LO 2
`define IDR_CTRL_START_LO 4
`define IDR_CTRL_END_LO  6
`define IDR_CTRL_RST     8'h00
`define IDR_VAL_RST      16'h0000

`define IDR_MODE_NONE    2'h0
`define IDR_MODE_RISE    2'h1
`define IDR_MODE_FALL    2'h2
`define IDR_MODE_BOTH    2'h3

`define IDR_REACT_NONE   2'h0
`define IDR_REACT_RISE   2'h1
`define IDR_REACT_FALL   2'h2
`define IDR_REACT_STATE  2'h3

`endif

// ==== idr_sink.sv ====
// Purpose: Telegram receiver model for one channel
// Assumes: Strobe is a one-cycle pulse
// Notes:   Counts telegrams, keeps the last value
`timescale 1ns/10ps
`default_nettype none
module idr_sink
(
	input  wire logic       clk,
	input  wire logic       stb,
	input  wire logic [7:0] val,
	output var logic [7:0]  cnt,
	output var logic [7:0]  last
);
	initial cnt = 8'h00;
	always @(posedge clk)
		if (stb)
		begin
			cnt <= cnt + 8'h01;
			last <= val;
		end
endmodule // idr_sink
`default_nettype wire

// ==== idr_asserts.sv ====
// Purpose: Port checks of the disable stage
// Assumes: One clock, RST_N synchronous
// Notes:   Bound to idr_top below
`timescale 1ns/10ps
`default_nettype none
module idr_asserts
(
	input wire logic SYS_CLK, RST_N, WB_CYC_I, WB_STB_I, WB_ACK_O,
	input wire logic [31:0] WB_DAT_O,
	input wire logic [1:0]  TX_STB, DISABLED,
	input wire logic [7:0]  TX_VAL0, TX_VAL1
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	chk_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O
		|=> WB_ACK_O) else $error("ack missing");
	chk_ack_once: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack too long");
	chk_ack_cause: assert property (WB_ACK_O |-> $past(WB_STB_I))
		else $error("ack without request");
	chk_dat_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
		else $error("read data not zero");
	chk_quiet_ch0: assert property (
		TX_STB[0] && DISABLED[0] |-> $rose(DISABLED[0]))
		else $error("channel 0 sent while disabled");
	chk_quiet_ch1: assert property (
		TX_STB[1] && DISABLED[1] |-> $rose(DISABLED[1]))
		else $error("channel 1 sent while disabled");
	chk_val_hold0: assert property (
		!TX_STB[0] |-> $stable(TX_VAL0)) else $error("value 0 moved");
	chk_val_hold1: assert property (
		!TX_STB[1] |-> $stable(TX_VAL1)) else $error("value 1 moved");
	cover property ($rose(DISABLED[0]) && TX_STB[0]);
	cover property ($fell(DISABLED[0]) && TX_STB[0]);
	cover property ($rose(DISABLED[1]) && TX_STB[1]);
endmodule // idr_asserts
bind idr_top idr_asserts chk (.SYS_CLK, .RST_N, .WB_CYC_I, .WB_STB_I,
	.WB_ACK_O, .WB_DAT_O, .TX_STB, .DISABLED, .TX_VAL0, .TX_VAL1);
`default_nettype wire

// ==== test_idr_top.sv ====
// Purpose: Self-checking bench of idr_top
// Assumes: 125 MHz clock, Wishbone classic
// Notes:   Walks all reactions on both channels
`timescale 1ns/10ps
`default_nettype none
`include "idr_regs.vh"
module test_idr_top;
	logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0]  adr = 8'h00, k, a;
	logic [31:0] dat = 32'h0, rd;
	logic [1:0]  btn = 2'h0, obj = 2'h0;
	wire  [31:0] dat_o;
	wire         ack;
	wire  [1:0]  tx, dis;
	wire  [7:0]  v0, v1, n0, n1, l0, l1;
	int          err_total = 0, samples_checked = 0, c, r;
	idr_top dut (.SYS_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
		.WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .BTN_IN(btn),
		.DIS_OBJ(obj), .TX_STB(tx), .TX_VAL0(v0), .TX_VAL1(v1),
		.DISABLED(dis));
	idr_sink s0 (.clk(clk), .stb(tx[0]), .val(v0), .cnt(n0), .last(l0));
	idr_sink s1 (.clk(clk), .stb(tx[1]), .val(v1), .cnt(n1), .last(l1));
	initial forever #4 clk = ~clk;
	task wrap_up;
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		int i;
		i = 0;
		@(posedge clk);
		{cyc, stb, we, adr, dat} <= {2'b11, w, ad, d};
		do
			@(posedge clk);
		while (ack !== 1'b1 && ++i < 20);
		rd = dat_o;
		{cyc, stb} <= 2'b00;
		if (ack !== 1'b1)
		begin
			err_total++;
			wrap_up;
		end
	endtask
	// Telegram lands one cycle after the input; three leave margin
	task settle;
		repeat (3) @(posedge clk);
	endtask
	initial
	begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		wb(0, `IDR_OFS_CTRL0, 0);
		check(rd, `IDR_CTRL_RST);
		wb(0, 8'h14, 0);
		check(rd, 0);
		btn <= 2'h3;
		for (c = 0; c < 2; c++)
			for (r = 0; r < 4; r++)
			begin
				a = 8'(c * 8);
				wb(1, a + `IDR_OFS_VAL0, 32'hB4A5);
				wb(1, a, {r[1:0], r[1:0], 4'hD});
				k = c ? n1 : n0;
				obj[c] <= 1'b1;
				settle;
				check(dis[c], 1);
				check((c ? n1 : n0) - k, r != 0);
				if (r != 0)
					check(c ? l1 : l0, r == 2 ? 8'hB4 : 8'hA5);
				wb(0, `IDR_OFS_STATUS, 0);
				check(rd, 32'hC | (32'h1 << c));
				btn[c] <= 1'b0;
				settle;
				obj[c] <= 1'b0;
				settle;
				check((c ? n1 : n0) - k, 2 * (r != 0));
				if (r != 0)
					check(c ? l1 : l0, r == 1 ? 8'hA5 : 8'hB4);
				btn[c] <= 1'b1;
				settle;
				check((c ? n1 : n0) - k, 2 * (r != 0) + 1);
				check(c ? l1 : l0, 8'hA5);
			end
		// Rising-only mode must refuse falling and state reactions, falling-only mode a rising one
		k = n0;
		wb(1, `IDR_OFS_CTRL0, 8'hE7);
		settle;
		check(dis[0], 1);
		check(n0 - k, 0);
		obj[0] <= 1'b1;
		settle;
		check(n0 - k, 0);
		wb(1, `IDR_OFS_CTRL0, 8'h19);
		settle;
		check(dis[0], 1);
		check(n0 - k, 0);
		wb(1, `IDR_OFS_CTRL0, 8'hE6);
		obj[0] <= 1'b0;
		settle;
		check(dis[0], 0);
		check(n0 - k, 0);
		wrap_up;
	end
endmodule // test_idr_top
`default_nettype wire
